/* File: inc/drf_pkg.sv */
// Function
// RULE_01 - controller times write-to-read spacing from first edge after last write beat
// RULE_02 - controller waits write recovery after last write data before precharge
// RULE_03 - burst field value 10 makes reads and writes fixed four-beat chops
// RULE_04 - cs, ras, cas low, we high, cke high decodes refresh
// RULE_05 - controller precharges all banks and waits precharge time before refresh
// RULE_06 - refresh rows come from internal counter; banks end precharged idle
// RULE_07 - controller issues only nop or deselect until refresh cycle time passes
// RULE_08 - controller postpones at most eight refreshes; gap under nine intervals
// RULE_09 - at most eight refreshes pulled in for credit
// RULE_10 - controller issues at most sixteen refreshes in two intervals
// RULE_11 - refresh debt frozen through self-refresh; total postponement at most eight
// RULE_12 - cs, ras, cas, cke low with we high decodes self-refresh entry
// RULE_13 - controller enters self-refresh only from idle with timings met
// RULE_14 - controller turns termination off before self-refresh entry
// RULE_15 - cke held low keeps self-refresh; only cke and reset matter
// RULE_16 - dll enabled mode: dll off on entry, reset and on at exit
// RULE_17 - device refreshes within cke period then from its own timer
// RULE_18 - controller stays in self-refresh at least the minimum residency
// RULE_19 - controller changes clock only after entry delay, restores before exit
// RULE_20 - exit is cke high with nop; exit delays before further commands
// RULE_21 - controller delays first write or leveling 512 clocks after exit
// RULE_22 - cke high and termination off through exit period; re-entry needs refresh
// RULE_23 - controller keeps signed refresh debt between minus and plus eight
package drf_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TRFC_NS = 260;
	localparam int TRFC_CYC = (TRFC_NS * CLK_MHZ + 999) / 1000;
	localparam int TCKE_NS = 5;
	localparam int TCKE_CYC = (TCKE_NS * CLK_MHZ) / 1000 < 1 ? 1
		: (TCKE_NS * CLK_MHZ) / 1000;
	localparam int TREFI_NS = 7800;
	localparam int TREFI_CYC = (TREFI_NS * CLK_MHZ) / 1000;
	localparam int NUM_BANKS = 8;
	localparam int ROW_W = 15;
	localparam logic [1:0] BL_CHOP4 = 2'h2;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_ROW = 8'h08;
	localparam logic [7:0] REG_CNT = 8'h0C;
	localparam int CTRL_BL_LSB = 0;
	localparam int CTRL_DLLDIS_BIT = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REFRESH = 2'b01,
		ST_SELF = 2'b10
	} drf_state_type;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
	} drf_cmd_type;
endpackage

/* File: rtl/drf_core.sv */
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module drf_core #(
	parameter int TREFI_CYCLES = drf_pkg::TREFI_CYC
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire drf_pkg::drf_cmd_type cmd_pins,
	input  wire logic               rst_pin_n,
	output logic                    busy_refresh,
	output logic                    in_self_refresh,
	output logic                    dll_on,
	output logic                    dll_reset_pulse,
	output logic                    burst_chop,
	output logic [14:0]             refresh_row,
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);
	import drf_pkg::*;

	// pin synchroniser, three stages; second and third must agree
	drf_cmd_type cmd_s1_reg, cmd_s2_reg, cmd_s3_reg, cmd_reg;
	logic        rst_s1_reg, rst_s2_reg, rst_s3_reg, rst_ok_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_s1_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			cmd_s2_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			cmd_s3_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			cmd_reg    <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
			rst_s3_reg <= 1'b0;
			rst_ok_reg <= 1'b0;
		end else begin
			cmd_s1_reg <= cmd_pins;
			cmd_s2_reg <= cmd_s1_reg;
			cmd_s3_reg <= cmd_s2_reg;
			if (cmd_s2_reg == cmd_s3_reg)
				cmd_reg <= cmd_s3_reg;
			rst_s1_reg <= rst_pin_n;
			rst_s2_reg <= rst_s1_reg;
			rst_s3_reg <= rst_s2_reg;
			if (rst_s2_reg == rst_s3_reg)
				rst_ok_reg <= rst_s3_reg;
		end
	end

	// one decoded command per filtered change; avoids repeat decodes
	drf_cmd_type prev_cmd_reg;
	logic        cmd_new;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			prev_cmd_reg <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		else
			prev_cmd_reg <= cmd_reg;
	end
	assign cmd_new = (cmd_reg != prev_cmd_reg) ||
		(!cmd_reg.cs_n && prev_cmd_reg.cs_n);

	logic dec_ref, dec_sre, dec_srx;
	// decode of refresh and self-refresh commands
	assign dec_ref = cmd_new && !cmd_reg.cs_n && !cmd_reg.ras_n &&
		!cmd_reg.cas_n && cmd_reg.we_n && cmd_reg.cke; // RULE_04
	assign dec_sre = cmd_new && !cmd_reg.cs_n && !cmd_reg.ras_n &&
		!cmd_reg.cas_n && cmd_reg.we_n && !cmd_reg.cke; // RULE_12
	assign dec_srx = cmd_reg.cke &&
		(cmd_reg.cs_n || (cmd_reg.ras_n && cmd_reg.cas_n && cmd_reg.we_n));

	// software-visible control and status words
	logic [31:0]   ctrl_reg;
	logic [31:0]   ref_cnt_reg;

	// sequencing state; one refresh timer shared by both refresh kinds
	drf_state_type state_reg;
	logic [15:0]   cyc_reg;
	logic [15:0]   self_tmr_reg;
	logic [14:0]   row_reg;
	logic          busy_reg;
	logic          self_reg;
	logic          dll_reg;
	logic          dllrst_reg;
	logic          chop_reg;

	// handshake terms of the command decode and the bus
	logic          ext_ref_go;
	logic          int_ref_go;
	logic          sre_go;
	logic          srx_go;
	logic          wr_go;
	logic          rd_go;

	// cuts an int timing count down to the counter width
	function automatic logic [15:0] cnt16(input int v);
		return v[15:0];
	endfunction

	// true when a bus address names one register word exactly
	function automatic logic addr_hit(
		input logic [31:0] a,
		input logic [7:0]  off
	);
		return (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction

	// refresh only from idle and with no refresh still running
	assign ext_ref_go = (state_reg == ST_IDLE) && dec_ref &&
		(cyc_reg == 16'h0000); // RULE_04
	// internal refresh when the self-refresh timer runs out
	assign int_ref_go = (state_reg == ST_SELF) &&
		(self_tmr_reg == 16'h0001) && (cyc_reg == 16'h0000); // RULE_17
	// entry and exit; the two decodes differ in cke so never clash
	assign sre_go = (state_reg == ST_IDLE) && dec_sre; // RULE_12
	assign srx_go = (state_reg == ST_SELF) && dec_srx; // RULE_15

	// command state: idle, external refresh or self-refresh
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_ok_reg) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (ext_ref_go)
						state_reg <= ST_REFRESH; // RULE_04
					else if (sre_go)
						state_reg <= ST_SELF; // RULE_12
				end
				ST_REFRESH: begin
					// every command is ignored until the cycle ends
					if (cyc_reg == 16'h0001)
						state_reg <= ST_IDLE; // RULE_06
				end
				ST_SELF: begin
					// pins other than cke are noise while cke stays low
					if (srx_go)
						state_reg <= ST_IDLE; // RULE_15
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// refresh cycle timer; keeps running after exit, which tXS covers
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_ok_reg) begin
			cyc_reg  <= 16'h0000;
			busy_reg <= 1'b0;
		end else if (ext_ref_go || int_ref_go) begin
			cyc_reg  <= cnt16(TRFC_CYC);
			busy_reg <= 1'b1;
		end else if (cyc_reg != 16'h0000) begin
			cyc_reg  <= cyc_reg - 16'h0001;
			busy_reg <= (cyc_reg != 16'h0001);
		end
	end

	// self-refresh timer: first tick after tCKE, then once an interval
	// limitation: it runs on aclk, so a halted clock halts it too
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_ok_reg) begin
			self_tmr_reg <= 16'h0000;
		end else if (sre_go) begin
			self_tmr_reg <= cnt16(TCKE_CYC); // RULE_17
		end else if (state_reg == ST_SELF) begin
			if (self_tmr_reg == 16'h0001)
				self_tmr_reg <= cnt16(TREFI_CYCLES); // RULE_17
			else
				self_tmr_reg <= self_tmr_reg - 16'h0001;
		end else begin
			self_tmr_reg <= 16'h0000;
		end
	end

	// row counter of its own; address pins take no part in refresh
	always_ff @(posedge aclk) begin
		if (!aresetn)
			row_reg <= 15'h0000;
		else if (ext_ref_go || int_ref_go)
			row_reg <= row_reg + 15'h0001; // RULE_06
	end

	// running count of refreshes done, both kinds
	always_ff @(posedge aclk) begin
		if (!aresetn)
			ref_cnt_reg <= 32'h00000000;
		else if (ext_ref_go || int_ref_go)
			ref_cnt_reg <= ref_cnt_reg + 32'h00000001;
	end

	// self-refresh flag, set and cleared on the state's own edges
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_ok_reg)
			self_reg <= 1'b0;
		else if (sre_go)
			self_reg <= 1'b1; // RULE_12
		else if (srx_go)
			self_reg <= 1'b0; // RULE_15
	end

	// dll follows self-refresh when enabled, and only then does exit bring a reset pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dll_reg    <= !CTRL_RESET[CTRL_DLLDIS_BIT];
			dllrst_reg <= 1'b0;
		end else begin
			dllrst_reg <= 1'b0;
			if (ctrl_reg[CTRL_DLLDIS_BIT]) begin
				dll_reg <= 1'b0;
			end else if (sre_go) begin
				dll_reg <= 1'b0; // RULE_16
			end else if (srx_go) begin
				dll_reg    <= 1'b1; // RULE_16
				dllrst_reg <= 1'b1; // RULE_16
			end else if (!dll_reg && state_reg != ST_SELF) begin
				// software enabled it again: relock with a reset too
				dll_reg    <= 1'b1;
				dllrst_reg <= 1'b1;
			end
		end
	end

	// burst field decode, registered so the output comes from a flop
	always_ff @(posedge aclk) begin
		if (!aresetn)
			chop_reg <= 1'b0;
		else
			chop_reg <= (ctrl_reg[CTRL_BL_LSB +: 2] == BL_CHOP4); // RULE_03
	end

	// write side: address and data taken together, one write at a time
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;

	// control word; only the burst and dll fields are writable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wr_go && s_axi_wstrb[0] &&
			addr_hit(s_axi_awaddr, REG_CTRL)) begin
			ctrl_reg[CTRL_BL_LSB +: 2] <= s_axi_wdata[CTRL_BL_LSB +: 2];
			ctrl_reg[CTRL_DLLDIS_BIT]  <= s_axi_wdata[CTRL_DLLDIS_BIT];
		end
	end

	// write response; writes to status words are refused
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (addr_hit(s_axi_awaddr, REG_CTRL))
				s_axi_bresp <= RESP_OKAY;
			else
				s_axi_bresp <= RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// read side: one read at a time, answered the cycle after it is taken
	assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// read data and response; unknown words read zero with an error
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			if (s_axi_araddr[31:8] != 24'h000000) begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= RESP_SLVERR;
			end else begin
				case (s_axi_araddr[7:0])
					REG_CTRL: begin
						s_axi_rdata <= ctrl_reg;
					end
					REG_STAT: begin
						s_axi_rdata <= {29'h00000000, dll_reg, self_reg,
							busy_reg};
					end
					REG_ROW: begin
						s_axi_rdata <= {17'h00000, row_reg};
					end
					REG_CNT: begin
						s_axi_rdata <= ref_cnt_reg;
					end
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// outputs straight from their flops
	assign busy_refresh    = busy_reg;
	assign in_self_refresh = self_reg;
	assign dll_on          = dll_reg;
	assign dll_reset_pulse = dllrst_reg;
	assign burst_chop      = chop_reg;
	assign refresh_row     = row_reg;
endmodule

/* File: bench/drf_core_properties.sv */
`timescale 1ns/1ps
module drf_chk (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire drf_pkg::drf_cmd_type cmd_pins,
	input wire logic                 busy_refresh,
	input wire logic                 in_self_refresh,
	input wire logic                 dll_on,
	input wire logic                 dll_reset_pulse,
	input wire logic [14:0]          refresh_row
);
	import drf_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// free: neither refreshing nor in self-refresh
	wire bz = busy_refresh;
	wire sr = in_self_refresh;
	wire free = !bz && !sr;
	a_ref_go: assert property (
		cmd_pins == 5'h03 && free |-> ##[1:6] bz) else $error("no refresh");
	a_row_step: assert property (
		$rose(bz) |-> ##[0:2] $changed(refresh_row)) else $error("row stuck");
	a_sre_go: assert property (
		cmd_pins == 5'h02 && free |-> ##[1:6] sr) else $error("no entry");
	a_sr_hold: assert property (
		sr && !cmd_pins.cke |=> sr) else $error("left self-refresh");
	a_dll_off: assert property (
		$rose(sr) |-> ##[0:2] !dll_on) else $error("dll still on");
	a_dll_reset: assert property (
		$rose(dll_on) |-> dll_reset_pulse) else $error("no dll reset");
	a_sr_ref: assert property (
		$rose(sr) |-> ##[0:8] bz) else $error("no internal refresh");
endmodule
bind drf_core drf_chk drf_chk_i (.aclk(aclk), .aresetn(aresetn),
	.cmd_pins(cmd_pins), .busy_refresh(busy_refresh),
	.in_self_refresh(in_self_refresh), .dll_on(dll_on),
	.dll_reset_pulse(dll_reset_pulse),
	.refresh_row(refresh_row));

/* File: bench/drf_ctrl_model.sv */
`timescale 1ns/1ps
module drf_ctrl_model (
	input wire logic             aclk,
	output drf_pkg::drf_cmd_type cmd
);
	import drf_pkg::*;
	initial cmd = 5'h1F;
	// one command, then idle edges long enough for every wait
	task automatic send(input logic [4:0] c, input int gap);
		@(posedge aclk);
		cmd <= c;
		// held three edges so the pin filter lets it through
		repeat (3) @(posedge aclk);
		// no writes, one refresh, one short visit: debt stays in limits
		repeat (gap) begin
			@(posedge aclk);
			// cke low: other pins are noise the device must ignore
			cmd <= c[0] ? 5'h1F : {~cmd[4:1], 1'b0};
		end
	endtask
endmodule

/* File: bench/tb_drf_core.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_drf_core;
	import drf_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
	logic awr, wrdy, bv, arr, rv, bz, sr, dll, chop;
	logic [31:0] aw = 0, wd = 0, rd, q;
	logic [1:0] br, rr, r;
	logic [14:0] row, row0;
	drf_cmd_type cmd;
	int err_count = 0, tests_run = 0;
	always #5 aclk = ~aclk;
	drf_ctrl_model drf_ctrl_model_i (.aclk(aclk), .cmd(cmd));
	drf_core drf_core_i (.aclk(aclk), .aresetn(aresetn), .cmd_pins(cmd),
		.rst_pin_n(1'b1), .busy_refresh(bz), .in_self_refresh(sr),
		.dll_on(dll), .dll_reset_pulse(), .burst_chop(chop),
		.refresh_row(row), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(aw),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry));
	// one bus access; handshakes sampled 1 ns after each edge
	task automatic bus(input logic w, input logic [31:0] a, d);
		logic ta, tw, tr, tv;
		@(posedge aclk);
		aw <= a;
		wd <= d;
		{awv, wv, bry, arv, rry} <= w ? 5'h1C : 5'h03;
		for (int n = 0; n < 50; n++) begin
			#1 {ta, tw, tr, tv} = {awr, wrdy, arr, w ? bv : rv};
			q = rd;
			r = w ? br : rr;
			@(posedge aclk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
			if (tr) arv <= 0;
			if (tv) begin
				{bry, rry} <= 2'h0;
				return;
			end
		end
		err_count++;
		tally_and_finish();
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// registers, one refresh, then a self-refresh round trip
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		bus(0, REG_CTRL, 0);
		`CHK(q, CTRL_RESET)
		bus(1, REG_CTRL, {30'h0, BL_CHOP4});
		bus(0, REG_CTRL, 0);
		`CHK({q[1:0], chop}, {BL_CHOP4, 1'b1})
		bus(0, 32'h40, 0);
		`CHK(r, RESP_SLVERR)
		$display("registers done");
		row0 = row;
		drf_ctrl_model_i.send(5'h03, TRFC_CYC + 4);
		#1 `CHK({row, bz}, {row0 + 15'h1, 1'b0})
		$display("refresh done");
		row0 = row;
		drf_ctrl_model_i.send(5'h02, 20);
		#1 `CHK({sr, dll}, 2'b10)
		drf_ctrl_model_i.send(5'h1F, 30);
		#1 `CHK({sr, dll, row != row0}, 3'b011)
		bus(0, REG_STAT, 0);
		`CHK(q, 32'h0000_0004)
		bus(0, REG_CNT, 0);
		`CHK(q, 32'h0000_0002)
		$display("self refresh done");
		tally_and_finish();
	end
endmodule
